// File: ima_onewire.sv
// Shared constants and the single-wire bit slot engine
`timescale 1ns/10ps
package ima_pkg;
    // ****************************************
    // Clock and bus timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned T_RSTL_NS     = 480000;
    localparam int unsigned T_PDS_NS      = 70000;
    localparam int unsigned T_RSTH_NS     = 480000;
    localparam int unsigned T_SLOT_NS     = 65000;
    localparam int unsigned T_LOW1_NS     = 6000;
    localparam int unsigned T_LOW0_NS     = 60000;
    localparam int unsigned T_RDS_NS      = 12000;
    localparam int unsigned RSTL_CYC =
        (T_RSTL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PDS_CYC =
        (T_PDS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RSTH_CYC =
        (T_RSTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLOT_CYC =
        (T_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOW1_CYC =
        (T_LOW1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOW0_CYC =
        (T_LOW0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RDS_CYC =
        (T_RDS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 17;
    // ****************************************
    // Bit engine operations
    // ****************************************
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    // ****************************************
    // Command modes and page limits
    // ****************************************
    localparam logic [15:0] MODE_MOT_RD  = 16'h0000;
    localparam logic [15:0] MODE_MOT_WR  = 16'h0001;
    localparam logic [15:0] MODE_MOT_SN  = 16'h0002;
    localparam logic [15:0] MODE_AUX_RD  = 16'h0003;
    localparam logic [15:0] MODE_AUX_WR  = 16'h0004;
    localparam logic [15:0] MODE_AUX_SN  = 16'h0005;
    localparam logic [15:0] MOT_PAGES    = 16'h0010;
    localparam logic [15:0] MOT_USER_LO  = 16'h000E;
    localparam logic [15:0] AUX_PAGES    = 16'h0040;
    localparam logic [15:0] REG_MIN      = 16'h000B;
    localparam logic [15:0] REG_MAX      = 16'h00C6;
    localparam int unsigned PAGE_BITS    = 64;
    localparam int unsigned PAGE_BYTE_SH = 3;
    // ****************************************
    // Memory chip command bytes
    // ****************************************
    localparam logic [7:0] CMD_SKIP_ROM = 8'h0CC;
    localparam logic [7:0] CMD_READ_ROM = 8'h033;
    localparam logic [7:0] CMD_WR_SCR   = 8'h00F;
    localparam logic [7:0] CMD_COPY_SCR = 8'h055;
    localparam logic [7:0] CMD_READ_MEM = 8'h0F0;
    localparam logic [3:0] HDR_LEN      = 4'h4;
    localparam logic [3:0] WR_LEN       = 4'hC;
    localparam logic [3:0] SN_LEN       = 4'h1;
    localparam logic [5:0] LAST_BIT     = 6'h3F;
    localparam logic [2:0] BYTE_LAST    = 3'h7;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {ST_IDLE, ST_RESET, ST_TX, ST_RX} ima_st_t;
    typedef enum logic [1:0] {K_WR, K_CP, K_RD, K_SN} ima_kind_t;
endpackage : ima_pkg

module ima_onewire #(
    parameter int unsigned RSTL_CYC = ima_pkg::RSTL_CYC,
    parameter int unsigned PDS_CYC  = ima_pkg::PDS_CYC,
    parameter int unsigned RSTH_CYC = ima_pkg::RSTH_CYC,
    parameter int unsigned SLOT_CYC = ima_pkg::SLOT_CYC,
    parameter int unsigned LOW1_CYC = ima_pkg::LOW1_CYC,
    parameter int unsigned LOW0_CYC = ima_pkg::LOW0_CYC,
    parameter int unsigned RDS_CYC  = ima_pkg::RDS_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_go,
    input  wire logic [1:0] i_op,
    input  wire logic       i_bit,
    input  wire logic       i_dq_in,
    output logic            o_done,
    output logic            o_bit,
    output logic            o_dq_out,
    output logic            o_dq_oe
);
    localparam int unsigned W = ima_pkg::CNT_W;
    localparam logic [W-1:0] L_RSTL = W'(RSTL_CYC);
    localparam logic [W-1:0] L_PDS  = W'(RSTL_CYC + PDS_CYC);
    localparam logic [W-1:0] L_REND = W'(RSTL_CYC + RSTH_CYC);
    localparam logic [W-1:0] L_SLOT = W'(SLOT_CYC);
    localparam logic [W-1:0] L_LOW1 = W'(LOW1_CYC);
    localparam logic [W-1:0] L_LOW0 = W'(LOW0_CYC);
    localparam logic [W-1:0] L_RDS  = W'(RDS_CYC);

    typedef struct packed {
        logic         busy;
        logic [1:0]   op;
        logic         wbit;
        logic [W-1:0] cnt;
        logic         done;
        logic         bit_q;
        logic         oe;
    } ima_ow_t;

    ima_ow_t q;
    ima_ow_t next_q;
    logic [W-1:0] low_len;
    logic [W-1:0] smp_at;
    logic [W-1:0] end_at;

    // ****************************************
    // Slot timing
    // ****************************************
    always_comb begin
        next_q      = q;
        next_q.done = 1'b0;
        low_len = (q.op == ima_pkg::OP_RESET) ? L_RSTL :
                  (q.op == ima_pkg::OP_WRITE && !q.wbit) ? L_LOW0 : L_LOW1;
        smp_at  = (q.op == ima_pkg::OP_RESET) ? L_PDS : L_RDS;
        end_at  = (q.op == ima_pkg::OP_RESET) ? L_REND : L_SLOT;
        if (!q.busy) begin
            next_q.oe = 1'b0;
            if (i_go) begin
                next_q.busy = 1'b1;
                next_q.op   = i_op;
                next_q.wbit = i_bit;
                next_q.cnt  = '0;
                next_q.oe   = 1'b1;
            end
        end else begin
            next_q.cnt = q.cnt + 1'b1;
            next_q.oe  = (next_q.cnt < low_len);
            if (q.cnt == smp_at) begin
                // Presence is low, read bit is line level
                next_q.bit_q = (q.op == ima_pkg::OP_RESET) ? !i_dq_in
                                                            : i_dq_in;
            end
            if (q.cnt == end_at) begin
                next_q.busy = 1'b0;
                next_q.done = 1'b1;
                next_q.oe   = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign o_done   = q.done;
    assign o_bit    = q.bit_q;
    assign o_dq_out = 1'b0;
    assign o_dq_oe  = q.oe;
endmodule : ima_onewire

// File: ima_top.sv
// Page access command executor for single-wire identification memories
// What this block does
// - Auxiliary memory: 64 pages, each page moves exactly two registers.
// - Memory reached over one-wire link on the motor memory port.
// - Command with motor driver enabled is refused with sequence error.
// - Serial mode reads the fixed read-only 64-bit serial number.
// - Serial mode ignores the page argument.
// - No checksum added or checked on user pages.
// - Data read back twice; copy mismatch is a comm error.
// - Status: zero success, positive errors, negative no memory.
// - Motor modes 0,1,2; auxiliary modes 3,4,5: read, write, serial.
// - Motor pages 0 to 13 readable but never user-writable.
// - Motor user writes only to pages 14 and 15.
`timescale 1ns/10ps
module ima_top #(
    parameter int unsigned RSTL_CYC    = ima_pkg::RSTL_CYC,
    parameter int unsigned PDS_CYC     = ima_pkg::PDS_CYC,
    parameter int unsigned RSTH_CYC    = ima_pkg::RSTH_CYC,
    parameter int unsigned SLOT_CYC    = ima_pkg::SLOT_CYC,
    parameter int unsigned LOW1_CYC    = ima_pkg::LOW1_CYC,
    parameter int unsigned LOW0_CYC    = ima_pkg::LOW0_CYC,
    parameter int unsigned RDS_CYC     = ima_pkg::RDS_CYC,
    parameter logic [1:0]  READ_PASSES = 2'h2
) (
    input  wire logic        I_MCLK,
    input  wire logic        I_RST,
    input  wire logic        I_CMD_VALID,
    input  wire logic        I_CMD_AUX,
    input  wire logic [15:0] I_MODE,
    input  wire logic [15:0] I_REG,
    input  wire logic [15:0] I_PAGE,
    input  wire logic        I_DRIVER_EN,
    input  wire logic [31:0] I_WR_DATA0,
    input  wire logic [31:0] I_WR_DATA1,
    input  wire logic        I_DQ_IN,
    output logic             O_CMD_READY,
    output logic             O_BUSY,
    output logic             O_DONE,
    output logic             O_SEQ_ERROR,
    output logic             O_ISW_ZERO,
    output logic             O_ISW_POS,
    output logic             O_ISW_NEG,
    output logic [15:0]      O_RD_REG,
    output logic [31:0]      O_RD_DATA0,
    output logic [31:0]      O_RD_DATA1,
    output logic [63:0]      O_SERIAL,
    output logic             O_DQ_OUT,
    output logic             O_DQ_OE
);
    typedef struct packed {
        ima_pkg::ima_st_t   st;
        ima_pkg::ima_kind_t kind;
        logic [1:0]         pass;
        logic               wait_e;
        logic               wr;
        logic               err;
        logic [3:0]         tx_idx;
        logic [5:0]         bit_idx;
        logic [7:0]         sh;
        logic [15:0]        addr;
        logic [63:0]        wdata;
        logic [63:0]        rx;
        logic [63:0]        first;
        logic               done;
        logic               seqerr;
        logic               zero;
        logic               pos;
        logic               neg;
        logic [15:0]        rreg;
        logic [63:0]        rdata;
        logic [63:0]        serial;
    } ima_state_t;

    ima_state_t q;
    ima_state_t next_q;
    logic       e_go;
    logic [1:0] e_op;
    logic       e_done;
    logic       e_bit;
    logic       take;
    logic       is_rd;
    logic       is_wr;
    logic       is_sn;
    logic       page_ok;
    logic [63:0] rx_next;
    logic [3:0]  tx_len;
    logic [15:0] mode_base;

    function automatic logic [7:0] tx_byte(
        input ima_pkg::ima_kind_t kind,
        input logic [3:0]         idx,
        input logic [15:0]        addr,
        input logic [63:0]        wdata
    );
        logic [7:0] b;
        b = ima_pkg::CMD_SKIP_ROM;
        if (kind == ima_pkg::K_SN) begin
            b = ima_pkg::CMD_READ_ROM;
        end else if (idx == 4'h1) begin
            b = (kind == ima_pkg::K_WR) ? ima_pkg::CMD_WR_SCR :
                (kind == ima_pkg::K_CP) ? ima_pkg::CMD_COPY_SCR :
                                          ima_pkg::CMD_READ_MEM;
        end else if (idx == 4'h2) begin
            b = addr[7:0];
        end else if (idx == 4'h3) begin
            b = addr[15:8];
        end else if (idx >= ima_pkg::HDR_LEN) begin
            b = wdata[8*(3'(idx - ima_pkg::HDR_LEN)) +: 8];
        end
        return b;
    endfunction : tx_byte

    // ****************************************
    // Command decode
    // ****************************************
    assign take      = I_CMD_VALID && (q.st == ima_pkg::ST_IDLE);
    assign mode_base = I_CMD_AUX ? ima_pkg::MODE_AUX_RD : ima_pkg::MODE_MOT_RD;
    assign is_rd     = (I_MODE == mode_base);
    assign is_wr     = (I_MODE == mode_base + ima_pkg::MODE_MOT_WR);
    assign is_sn     = (I_MODE == mode_base + ima_pkg::MODE_MOT_SN);
    assign page_ok   = I_CMD_AUX ? (I_PAGE < ima_pkg::AUX_PAGES) :
                       (I_PAGE < ima_pkg::MOT_PAGES) &&
                       (!is_wr || I_PAGE >= ima_pkg::MOT_USER_LO);
    assign rx_next   = {e_bit, q.rx[63:1]};
    assign tx_len    = (q.kind == ima_pkg::K_WR) ? ima_pkg::WR_LEN :
                       (q.kind == ima_pkg::K_SN) ? ima_pkg::SN_LEN :
                                                   ima_pkg::HDR_LEN;
    assign e_go      = (q.st != ima_pkg::ST_IDLE) && !q.wait_e;
    assign e_op      = (q.st == ima_pkg::ST_RESET) ? ima_pkg::OP_RESET :
                       (q.st == ima_pkg::ST_TX) ? ima_pkg::OP_WRITE :
                                                   ima_pkg::OP_READ;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        next_q        = q;
        next_q.done   = 1'b0;
        next_q.seqerr = 1'b0;
        if (e_go) begin
            next_q.wait_e = 1'b1;
        end
        if (e_done) begin
            next_q.wait_e = 1'b0;
        end
        case (q.st)
            ima_pkg::ST_IDLE: begin
                if (take) begin
                    if (I_DRIVER_EN) begin
                        next_q.seqerr = 1'b1;
                    end else if (!(is_rd || is_wr || is_sn) ||
                                 (!is_sn && !page_ok) ||
                                 I_REG < ima_pkg::REG_MIN ||
                                 I_REG > ima_pkg::REG_MAX) begin
                        next_q.done = 1'b1;
                        next_q.zero = 1'b0;
                        next_q.pos  = 1'b1;
                        next_q.neg  = 1'b0;
                    end else begin
                        next_q.kind = is_sn ? ima_pkg::K_SN :
                                      is_wr ? ima_pkg::K_WR : ima_pkg::K_RD;
                        next_q.wr    = is_wr;
                        next_q.err   = 1'b0;
                        next_q.pass  = '0;
                        next_q.rreg  = I_REG;
                        next_q.addr  = I_PAGE << ima_pkg::PAGE_BYTE_SH;
                        next_q.wdata = {I_WR_DATA1, I_WR_DATA0};
                        next_q.st    = ima_pkg::ST_RESET;
                    end
                end
            end
            ima_pkg::ST_RESET: begin
                if (e_done) begin
                    if (!e_bit) begin
                        next_q.st   = ima_pkg::ST_IDLE;
                        next_q.done = 1'b1;
                        next_q.zero = 1'b0;
                        next_q.pos  = 1'b0;
                        next_q.neg  = 1'b1;
                    end else begin
                        next_q.st      = ima_pkg::ST_TX;
                        next_q.tx_idx  = '0;
                        next_q.bit_idx = '0;
                        next_q.sh = tx_byte(q.kind, 4'h0, q.addr, q.wdata);
                    end
                end
            end
            ima_pkg::ST_TX: begin
                if (e_done) begin
                    next_q.sh      = q.sh >> 1;
                    next_q.bit_idx = q.bit_idx + 1'b1;
                    if (q.bit_idx[2:0] == ima_pkg::BYTE_LAST) begin
                        next_q.bit_idx = '0;
                        next_q.tx_idx  = q.tx_idx + 1'b1;
                        next_q.sh = tx_byte(q.kind, q.tx_idx + 1'b1,
                                            q.addr, q.wdata);
                        if (q.tx_idx + 1'b1 == tx_len) begin
                            if (q.kind == ima_pkg::K_WR) begin
                                next_q.kind = ima_pkg::K_CP;
                                next_q.st   = ima_pkg::ST_RESET;
                            end else if (q.kind == ima_pkg::K_CP) begin
                                next_q.kind = ima_pkg::K_RD;
                                next_q.st   = ima_pkg::ST_RESET;
                            end else begin
                                next_q.st = ima_pkg::ST_RX;
                            end
                        end
                    end
                end
            end
            ima_pkg::ST_RX: begin
                if (e_done) begin
                    next_q.rx      = rx_next;
                    next_q.bit_idx = q.bit_idx + 1'b1;
                    if (q.bit_idx == ima_pkg::LAST_BIT) begin
                        next_q.pass = q.pass + 1'b1;
                        if (q.pass == '0) begin
                            next_q.first = rx_next;
                        end else if (q.first != rx_next) begin
                            next_q.err = 1'b1;
                        end
                        if (q.wr && rx_next != q.wdata) begin
                            next_q.err = 1'b1;
                        end
                        if (q.pass + 1'b1 == READ_PASSES) begin
                            next_q.st   = ima_pkg::ST_IDLE;
                            next_q.done = 1'b1;
                            next_q.neg  = 1'b0;
                            next_q.zero = !next_q.err;
                            next_q.pos  = next_q.err;
                            if (!next_q.err && q.kind == ima_pkg::K_SN) begin
                                next_q.serial = rx_next;
                            end else if (!next_q.err) begin
                                next_q.rdata = rx_next;
                            end
                        end else begin
                            next_q.st = ima_pkg::ST_RESET;
                        end
                    end
                end
            end
            default: begin
                next_q = '0;
            end
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************
    // Line engine
    // ****************************************
    // One-wire link to the memory
    ima_onewire #(
        .RSTL_CYC (RSTL_CYC),
        .PDS_CYC  (PDS_CYC),
        .RSTH_CYC (RSTH_CYC),
        .SLOT_CYC (SLOT_CYC),
        .LOW1_CYC (LOW1_CYC),
        .LOW0_CYC (LOW0_CYC),
        .RDS_CYC  (RDS_CYC)
    ) u_line (
        .i_clk    (I_MCLK),
        .i_rst    (I_RST),
        .i_go     (e_go),
        .i_op     (e_op),
        .i_bit    (q.sh[0]),
        .i_dq_in  (I_DQ_IN),
        .o_done   (e_done),
        .o_bit    (e_bit),
        .o_dq_out (O_DQ_OUT),
        .o_dq_oe  (O_DQ_OE)
    );

    assign O_CMD_READY = (q.st == ima_pkg::ST_IDLE);
    assign O_BUSY      = (q.st != ima_pkg::ST_IDLE);
    assign O_DONE      = q.done;
    assign O_SEQ_ERROR = q.seqerr;
    assign O_ISW_ZERO  = q.zero;
    assign O_ISW_POS   = q.pos;
    assign O_ISW_NEG   = q.neg;
    assign O_RD_REG    = q.rreg;
    assign O_RD_DATA0  = q.rdata[31:0];
    assign O_RD_DATA1  = q.rdata[63:32];
    assign O_SERIAL    = q.serial;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);

    sequence s_take;
        I_CMD_VALID && O_CMD_READY && !I_DRIVER_EN &&
        I_REG >= ima_pkg::REG_MIN && I_REG <= ima_pkg::REG_MAX;
    endsequence
    sequence s_reject;
        O_DONE && O_ISW_POS && !O_ISW_ZERO ##1 !O_BUSY && !O_DQ_OE;
    endsequence

    property p_seq_refuse;
        I_CMD_VALID && O_CMD_READY && I_DRIVER_EN
            |=> O_SEQ_ERROR && !O_BUSY && !O_DONE;
    endproperty
    a_seq_refuse: assert property (p_seq_refuse)
        else $error("driver enabled command not refused");

    property p_prot_page;
        s_take and (!I_CMD_AUX && I_MODE == ima_pkg::MODE_MOT_WR &&
                    I_PAGE < ima_pkg::MOT_USER_LO) |=> s_reject;
    endproperty
    a_prot_page: assert property (p_prot_page)
        else $error("factory page write not rejected");

    property p_user_page;
        s_take and (!I_CMD_AUX && I_MODE == ima_pkg::MODE_MOT_WR &&
                    I_PAGE >= ima_pkg::MOT_USER_LO &&
                    I_PAGE < ima_pkg::MOT_PAGES) |=> O_BUSY ##1 O_DQ_OE;
    endproperty
    a_user_page: assert property (p_user_page)
        else $error("user page write not started");

    property p_bad_page;
        s_take and (I_CMD_AUX && I_MODE == ima_pkg::MODE_AUX_WR &&
                    I_PAGE >= ima_pkg::AUX_PAGES) |=> s_reject;
    endproperty
    a_bad_page: assert property (p_bad_page)
        else $error("out of range page accepted");

    property p_mode_map;
        s_take and (I_CMD_AUX && I_MODE == ima_pkg::MODE_MOT_RD)
            |=> O_DONE && O_ISW_POS;
    endproperty
    a_mode_map: assert property (p_mode_map)
        else $error("motor mode accepted on aux command");

    property p_serial_page;
        s_take and (I_CMD_AUX && I_MODE == ima_pkg::MODE_AUX_SN &&
                    I_PAGE >= ima_pkg::AUX_PAGES) |=> O_BUSY && !O_DONE;
    endproperty
    a_serial_page: assert property (p_serial_page)
        else $error("serial read blocked by page");

    property p_no_mem;
        q.st == ima_pkg::ST_RESET && e_done && !e_bit
            |=> O_DONE && O_ISW_NEG && !O_ISW_POS ##1 O_CMD_READY;
    endproperty
    a_no_mem: assert property (p_no_mem)
        else $error("absent memory not flagged negative");

    property p_status_one;
        O_DONE |-> $onehot({O_ISW_ZERO, O_ISW_POS, O_ISW_NEG});
    endproperty
    a_status_one: assert property (p_status_one)
        else $error("status bits not exclusive");

    property p_mismatch;
        q.st == ima_pkg::ST_RX && e_done && q.bit_idx == ima_pkg::LAST_BIT
            && q.pass != '0 && q.pass + 1'b1 == READ_PASSES
            && q.first != rx_next |=> O_DONE && O_ISW_POS && !O_ISW_ZERO;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("read copy mismatch not reported");

    property p_ser_ro;
        q.st == ima_pkg::ST_RESET && e_done && e_bit &&
            q.kind == ima_pkg::K_SN
            |=> q.sh == ima_pkg::CMD_READ_ROM && !q.wr;
    endproperty
    a_ser_ro: assert property (p_ser_ro)
        else $error("serial access with write");
endmodule : ima_top

// File: ima_mem_model.sv
// Single-wire memory model with one stored page and a serial number
`timescale 1ns/10ps
module ima_mem_model (
    input  wire logic        i_clk, i_oe, i_present, i_noisy,
    input  wire logic [63:0] i_serial,
    output logic             o_pull
);
    logic [7:0]  lc = 0, dc = 0, bc = 0, ix;
    logic [15:0] hdr = 0;
    logic [63:0] mem = 0;
    logic        rc = 0, low = 0, sr, rp;
    assign sr = hdr[7:0] == 8'h33;
    assign ix = bc - (sr ? 8'h08 : 8'h20);
    assign rp = (sr || hdr == 16'hF0CC) && !ix[7];
    assign o_pull = low && dc != 0;
    always @(posedge i_clk) begin
        lc <= i_oe ? lc + 8'h01 : 8'h00;
        dc <= dc - (dc != 0);
        if (i_oe && lc == 0) begin
            dc <= 8'h0A;
            low <= rp && (i_noisy & rc) ==
                (sr ? i_serial[ix[5:0]] : mem[ix[5:0]]);
        end else if (!i_oe && lc > 8'h1E) begin
            {bc, hdr, rc} <= {8'h00, 16'h0000, !rc};
            {dc, low} <= {8'h1E, i_present};
        end else if (!i_oe && lc != 0) begin
            bc <= bc + 8'h01;
            if (bc < 8'h10) hdr[bc[3:0]] <= lc < 8'h0A;
            if (hdr == 16'h0FCC && !ix[7]) mem[ix[5:0]] <= lc < 8'h0A;
        end
    end
endmodule : ima_mem_model

// File: tb.sv
// Bench for the page access executor against the memory model
`timescale 1ns/10ps
module tb;
    logic        I_MCLK = 0, I_RST = 1, I_CMD_VALID = 0, I_CMD_AUX = 0;
    logic        I_DRIVER_EN = 0, pres = 1, nsy = 0, pull, I_DQ_IN, O_DQ_OE;
    logic        O_DONE, O_SEQ_ERROR, O_ISW_ZERO, O_ISW_POS, O_ISW_NEG;
    logic        O_CMD_READY, O_BUSY, O_DQ_OUT;
    logic [15:0] I_MODE = 0, I_REG = 16'h0014, I_PAGE = 0, O_RD_REG;
    logic [31:0] I_WR_DATA0 = 0, I_WR_DATA1 = 0, O_RD_DATA0, O_RD_DATA1, r;
    logic [63:0] sh = 0, O_SERIAL, sn = 64'h0123_4567_89AB_CDEF;
    logic [2:0]  last = 0;
    logic [32:0] tbl [12] = '{33'h0_0001_0003, 33'h0_0001_000E,
        33'h0_0000_000E, 33'h0_0000_0000, 33'h0_0001_000F, 33'h1_0004_003F,
        33'h1_0003_003F, 33'h1_0004_0040, 33'h1_0000_0002, 33'h0_0002_9999,
        33'h1_0005_0077, 33'h0_0006_0000};
    int          fails = 0, num_checks = 0, seed = 93870;
    assign I_DQ_IN = !(O_DQ_OE | pull);
    ima_top #(.RSTL_CYC(40), .PDS_CYC(8), .RSTH_CYC(40), .SLOT_CYC(20),
        .LOW1_CYC(2), .LOW0_CYC(15), .RDS_CYC(5)) ima_top_i (.*);
    ima_mem_model ima_mem_model_i (.i_clk(I_MCLK), .i_oe(O_DQ_OE),
        .i_present(pres), .i_noisy(nsy), .i_serial(sn), .o_pull(pull));
    task automatic chk(string nm, logic [79:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    function automatic logic [2:0] exp_st(logic a, logic [15:0] m, pv);
        logic ok;
        ok = (a ? m > 2 && m < 6 : m < 3) && I_REG > 10 && I_REG < 199 &&
            (m == 1 ? pv == 14 || pv == 15 : m != 0 || pv < 16) &&
            (m % 3 == 2 || a == 0 || pv < 64);
        return !ok ? 3'h2 : !pres ? 3'h1 : nsy ? 3'h2 : 3'h4;
    endfunction : exp_st
    task automatic run(logic a, logic [15:0] m, pv);
        logic [2:0] st;
        logic       bsy;
        st = I_DRIVER_EN ? last : exp_st(a, m, pv);
        bsy = !I_DRIVER_EN && (st != 3'h2 || nsy);
        {I_CMD_AUX, I_MODE, I_PAGE, I_CMD_VALID} = {a, m, pv, 1'b1};
        {I_WR_DATA0, I_WR_DATA1, sn} = {$random(seed), $random(seed),
            $random(seed), $random(seed)};
        @(posedge I_MCLK) #1 I_CMD_VALID = 0;
        chk("busy", {O_BUSY, O_CMD_READY, O_DQ_OUT}, {bsy, !bsy, 1'b0});
        for (int k = 0; k < 20000 && !(O_DONE | O_SEQ_ERROR); k++)
            @(posedge I_MCLK) #1;
        chk("status", {O_DONE, O_SEQ_ERROR, O_ISW_ZERO, O_ISW_POS,
            O_ISW_NEG}, {!I_DRIVER_EN, I_DRIVER_EN, st});
        if (st == 4 && m % 3 == 1) sh = {I_WR_DATA1, I_WR_DATA0};
        if (st == 4) chk("data", {O_RD_REG, m % 3 == 2 ? O_SERIAL :
            {O_RD_DATA1, O_RD_DATA0}}, {I_REG, m % 3 == 2 ? sn : sh});
        last = st;
        $display("test mode %0d page %0d ended", m, pv);
        @(posedge I_MCLK) #1;
    endtask : run
    initial forever #4 I_MCLK = !I_MCLK;
    initial begin
        repeat (100000) @(posedge I_MCLK);
        fails++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge I_MCLK);
        #1 I_RST = 0;
        I_DRIVER_EN = 1;
        run(0, 1, 14);
        I_DRIVER_EN = 0;
        foreach (tbl[i]) run(tbl[i][32], tbl[i][31:16], tbl[i][15:0]);
        repeat (3) begin
            r = $random(seed);
            I_REG = {8'h00, r[18:11]};
            run(r[0], {13'h0000, r[3:1]}, {9'h000, r[10:4]});
        end
        {I_REG, nsy} = {16'h00C6, 1'b1};
        run(1, 3, 1);
        {nsy, pres} = 2'h0;
        run(0, 0, 1);
        {pres, I_REG} = {1'b1, 16'h000A};
        run(0, 0, 1);
        I_DRIVER_EN = 1;
        run(1, 5, 0);
        end_sim();
    end
endmodule : tb
